// ---- verilog/host_port.sv ----
// isa / eisa slave host port: decode, strobes, ready and dma burst path
`default_nettype none

module host_port (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // configuration (pin strap and device base address)
  input wire logic i_eisa_mode,
  input wire logic [host_port_pkg::ADDR_MSB:host_port_pkg::DEC_LSB] i_base_addr,
  // host address and qualifiers
  input wire logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] i_address,
  input wire logic i_io_space_qualifier,
  input wire logic i_address_strobe_n,
  input wire logic [host_port_pkg::LANES-1:0] i_lane_enable_n,
  // host strobes
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  // host data pins (in, out, per-lane enable)
  input wire logic [host_port_pkg::DATA_W-1:0] i_data,
  output logic [host_port_pkg::DATA_W-1:0] o_data,
  output logic [host_port_pkg::LANES-1:0] o_data_oe,
  // host handshake outputs
  output logic o_async_ready_out,
  output logic o_local_device_decode_n,
  // eisa dma pins
  input wire logic i_dma_ack_n,
  input wire logic i_dma_write,
  input wire logic i_bus_clock,
  input wire logic i_exrdy,
  // internal register side
  input wire logic i_reg_busy,
  input wire logic [host_port_pkg::DATA_W-1:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] o_reg_addr,
  output logic [host_port_pkg::LANES-1:0] o_reg_lanes,
  output logic [host_port_pkg::DATA_W-1:0] o_wdata,
  // internal dma side
  input wire logic [host_port_pkg::DATA_W-1:0] i_dma_rdata,
  output logic o_dma_wr,
  output logic o_dma_rd_taken
);

  // ----------------------------------------
  // all state of the port
  // ----------------------------------------
  typedef struct packed {
    host_port_pkg::port_state_e state; // sequencer state
    logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] lat_addr; // held address
    logic lat_qual; // held io qualifier
    logic [host_port_pkg::LANES-1:0] lat_lane_n; // held lane enables
    logic rd_prev; // last read strobe level
    logic wr_prev; // last write strobe level
    logic bclk_prev; // last bus clock level
    logic ready; // ready output
    logic decode_n; // local decode output
    logic [host_port_pkg::DATA_W-1:0] data_out; // read data on pins
    logic [host_port_pkg::LANES-1:0] data_oe; // lane drive enables
    logic reg_wr; // register write pulse
    logic reg_rd; // register read pulse
    logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] reg_addr; // access address
    logic [host_port_pkg::LANES-1:0] reg_lanes; // active byte lanes
    logic [host_port_pkg::DATA_W-1:0] wdata; // captured write data
    logic dma_wr; // dma write pulse
    logic dma_rd_taken; // dma read word taken
  } port_s;

  port_s s_q; // registered state
  port_s s_d; // next state

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [host_port_pkg::SYNC_W-1:0] pins_raw; // asynchronous pin bundle
  logic [host_port_pkg::SYNC_W-1:0] pins_s; // synchronised pin bundle

  assign pins_raw = {i_address, i_io_space_qualifier, i_address_strobe_n, i_lane_enable_n,
                     i_read_strobe_n, i_write_strobe_n, i_data, i_dma_ack_n, i_dma_write,
                     i_bus_clock, i_exrdy, i_eisa_mode};

  pin_sync #(
    .WIDTH(host_port_pkg::SYNC_W)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] addr_s; // synced address
  logic qual_s; // synced qualifier
  logic ads_n_s; // synced address strobe
  logic [host_port_pkg::LANES-1:0] lane_n_s; // synced lane enables
  logic rd_n_s; // synced read strobe
  logic wr_n_s; // synced write strobe
  logic [host_port_pkg::DATA_W-1:0] data_s; // synced data pins
  logic dma_ack_n_s; // synced dma acknowledge
  logic dma_write_s; // synced dma direction
  logic bclk_s; // synced bus clock
  logic exrdy_s; // synced exrdy
  logic eisa_s; // synced mode strap

  assign {addr_s, qual_s, ads_n_s, lane_n_s, rd_n_s, wr_n_s, data_s, dma_ack_n_s,
          dma_write_s, bclk_s, exrdy_s, eisa_s} = pins_s;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // active-low lane enables to a used-lane mask; isa has two lanes
  function automatic logic [host_port_pkg::LANES-1:0] lane_map(
    input logic eisa,
    input logic [host_port_pkg::LANES-1:0] lane_n
  );
    logic [host_port_pkg::LANES-1:0] used;
    used = ~lane_n;
    if (!eisa)
    begin
      used[host_port_pkg::LANES-1:2] = 2'h0;
    end
    return used;
  endfunction

  // address compare on bits 15..4, qualifier low enables
  function automatic logic addr_hit(
    input logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] addr,
    input logic qual,
    input logic [host_port_pkg::ADDR_MSB:host_port_pkg::DEC_LSB] base
  );
    return (addr[host_port_pkg::ADDR_MSB:host_port_pkg::DEC_LSB] == base) && !qual;
  endfunction

  // eisa ignores a1 and a0: accesses are doubleword addressed
  function automatic logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] acc_addr(
    input logic eisa,
    input logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] addr
  );
    logic [host_port_pkg::ADDR_MSB:host_port_pkg::ADDR_LSB] a;
    a = addr;
    if (eisa)
    begin
      a[host_port_pkg::ADDR_LSB] = 1'b0;
    end
    return a;
  endfunction

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  logic hit; // current access decodes to this device
  logic [host_port_pkg::LANES-1:0] used; // lanes used by current access
  logic wr_fall; // write strobe leading edge
  logic wr_rise; // write strobe trailing edge
  logic rd_fall; // read strobe leading edge
  logic bclk_rise; // bus clock rising edge

  always_comb
  begin
    s_d = s_q;
    // pulses last one cycle
    s_d.reg_wr = 1'b0;
    s_d.reg_rd = 1'b0;
    s_d.dma_wr = 1'b0;
    s_d.dma_rd_taken = 1'b0;
    s_d.rd_prev = rd_n_s;
    s_d.wr_prev = wr_n_s;
    s_d.bclk_prev = bclk_s;

    wr_fall = !wr_n_s && s_q.wr_prev;
    wr_rise = wr_n_s && !s_q.wr_prev;
    rd_fall = !rd_n_s && s_q.rd_prev;
    bclk_rise = bclk_s && !s_q.bclk_prev;

    // R12 address latch: follows while strobe low, held after its rise
    if (!ads_n_s)
    begin
      s_d.lat_addr = addr_s;
      s_d.lat_lane_n = lane_n_s;
      // R13 qualifier latch
      s_d.lat_qual = qual_s;
    end

    hit = addr_hit(s_d.lat_addr, s_d.lat_qual, i_base_addr);
    used = lane_map(eisa_s, s_d.lat_lane_n);

    // R4 local decode
    s_d.decode_n = !hit;

    unique case (s_q.state)
      host_port_pkg::ST_IDLE:
      begin
        // R17 idle ready
        s_d.ready = 1'b1;
        s_d.data_oe = host_port_pkg::OE_RESET;
        if (wr_fall && hit)
        begin
          s_d.state = host_port_pkg::ST_WRITE;
          s_d.reg_addr = acc_addr(eisa_s, s_d.lat_addr);
          s_d.reg_lanes = used;
          // R2 ready drop, R8 never in eisa
          s_d.ready = !(i_reg_busy && !eisa_s);
        end
        else if (rd_fall && hit)
        begin
          s_d.state = host_port_pkg::ST_READ;
          s_d.reg_rd = 1'b1;
          s_d.reg_addr = acc_addr(eisa_s, s_d.lat_addr);
          s_d.reg_lanes = used;
          // R2 ready drop, R8 never in eisa
          s_d.ready = !(i_reg_busy && !eisa_s);
        end
        // R6 R15 dma only in eisa, strobes idle
        else if (eisa_s && !dma_ack_n_s && rd_n_s && wr_n_s)
        begin
          s_d.state = host_port_pkg::ST_DMA;
          s_d.reg_lanes = host_port_pkg::ALL_LANES;
        end
        else
        begin
          // nothing to start
          s_d.state = host_port_pkg::ST_IDLE;
        end
      end

      host_port_pkg::ST_WRITE:
      begin
        // R2 ready return
        if (!i_reg_busy)
        begin
          s_d.ready = 1'b1;
        end
        // R1 data capture
        if (wr_rise)
        begin
          s_d.wdata = data_s;
          s_d.reg_wr = 1'b1;
          s_d.ready = 1'b1;
          s_d.state = host_port_pkg::ST_IDLE;
        end
      end

      host_port_pkg::ST_READ:
      begin
        // R2 ready return
        if (!i_reg_busy)
        begin
          s_d.ready = 1'b1;
        end
        if (rd_n_s)
        begin
          // strobe gone: release pins
          s_d.data_oe = host_port_pkg::OE_RESET;
          s_d.ready = 1'b1;
          s_d.state = host_port_pkg::ST_IDLE;
        end
        else
        begin
          // R3 unused lanes tri-stated
          s_d.data_out = i_reg_rdata;
          s_d.data_oe = s_q.reg_lanes;
        end
      end

      host_port_pkg::ST_DMA:
      begin
        if (dma_ack_n_s)
        begin
          // burst over
          s_d.data_oe = host_port_pkg::OE_RESET;
          s_d.state = host_port_pkg::ST_IDLE;
        end
        // R11 hold while exrdy low; R9 one dword per bus clock
        else if (bclk_rise && exrdy_s)
        begin
          // R10 no alignment logic: doubleword lanes only
          if (dma_write_s)
          begin
            s_d.wdata = data_s;
            s_d.dma_wr = 1'b1;
            s_d.data_oe = host_port_pkg::OE_RESET;
          end
          else
          begin
            s_d.data_out = i_dma_rdata;
            s_d.data_oe = host_port_pkg::ALL_LANES;
            s_d.dma_rd_taken = 1'b1;
          end
        end
        else
        begin
          // wait for next bus clock edge
          s_d.state = host_port_pkg::ST_DMA;
        end
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      s_q <= '0;
      s_q.state <= host_port_pkg::ST_IDLE;
      s_q.lat_qual <= 1'b1;
      s_q.lat_lane_n <= '1;
      s_q.rd_prev <= 1'b1;
      s_q.wr_prev <= 1'b1;
      s_q.bclk_prev <= 1'b1;
      s_q.ready <= host_port_pkg::READY_RESET;
      s_q.decode_n <= host_port_pkg::DECODE_RESET;
      s_q.data_oe <= host_port_pkg::OE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs straight from the state register
  // ----------------------------------------
  assign o_data = s_q.data_out;
  assign o_data_oe = s_q.data_oe;
  assign o_async_ready_out = s_q.ready;
  assign o_local_device_decode_n = s_q.decode_n;
  assign o_reg_wr = s_q.reg_wr;
  assign o_reg_rd = s_q.reg_rd;
  assign o_reg_addr = s_q.reg_addr;
  assign o_reg_lanes = s_q.reg_lanes;
  assign o_wdata = s_q.wdata;
  assign o_dma_wr = s_q.dma_wr;
  assign o_dma_rd_taken = s_q.dma_rd_taken;

endmodule

`default_nettype wire

// ---- verilog/host_port_pkg.sv ----
// constants and types shared by the isa/eisa host slave port
// Behaviour
// R1: isa write data taken on strobe trailing edge
// R2: ready drops at strobe start, returns later
// R3: lane enables pick bytes; unused lanes idle
// R4: decode output low on address hit, qualifier low
// R5: isa board ties address strobe and upper pins
// R6: eisa mode is 32-bit slave with dma
// R7: eisa glue derives strobes from bus commands
// R8: eisa i/o cycles never stretched by ready
// R9: dma burst moves one dword per bus clock
// R10: host keeps dma doubleword aligned
// R11: dma held off while exrdy requests waits
// R12: eisa address latched on address strobe rise
// R13: qualifier transparent while strobe low, then held
// R14: board ors memory select and address enable
// R15: host keeps strobes idle during dma bursts
// R16: board drives lane enables from a0, sbhe
// R17: ready stays high while no strobe active
`default_nettype none

package host_port_pkg;

  // ----------------------------------------
  // widths and synchroniser depth
  // ----------------------------------------
  localparam int ADDR_MSB = 15; // top address bit seen by the port
  localparam int ADDR_LSB = 1; // lowest address bit on the port pins; a0 feeds lane enables
  localparam int DEC_LSB = 4; // lowest bit used by the local decode
  localparam int DATA_W = 32; // data pins
  localparam int LANES = 4; // byte lanes
  localparam int SYNC_STAGES = 2; // flip-flops on every pin input
  localparam int SYNC_W = 60; // width of the synchronised pin bundle

  // ----------------------------------------
  // values after reset, and the full lane mask
  // ----------------------------------------
  localparam logic READY_RESET = 1'b1; // ready high when idle
  localparam logic DECODE_RESET = 1'b1; // decode output inactive (high)
  localparam logic [LANES-1:0] OE_RESET = 4'h0; // data pins released
  localparam logic [LANES-1:0] ALL_LANES = 4'hf; // full doubleword

  // ----------------------------------------
  // port sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_DMA
  } port_state_e;

endpackage

`default_nettype wire

// ---- verilog/pin_sync.sv ----
// two-stage synchroniser bank for asynchronous pin inputs
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // asynchronous side
  input wire logic [WIDTH-1:0] i_async,
  // synchronised side
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q; // first stage, read only by the second
  logic [WIDTH-1:0] sync_q; // second stage

  // two flops per bit; reset to all ones so strobes read inactive
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// ---- verification/host_port_sva.sv ----
// concurrent checks on the host port pins
`default_nettype none
module host_port_sva (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // host side inputs
  input wire logic i_eisa_mode,
  input wire logic [15:4] i_base_addr,
  input wire logic [15:1] i_address,
  input wire logic i_io_space_qualifier,
  input wire logic i_address_strobe_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_reg_busy,
  input wire logic i_exrdy,
  // watched outputs
  input wire logic [3:0] o_data_oe,
  input wire logic o_async_ready_out,
  input wire logic o_local_device_decode_n,
  input wire logic o_reg_wr,
  input wire logic o_reg_rd,
  input wire logic [3:0] o_reg_lanes,
  input wire logic o_dma_wr,
  input wire logic o_dma_rd_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // sequences of an access
  // ----
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  // latch open, address and qualifier steady
  sequence s_addr_steady;
    (!i_address_strobe_n && $stable(i_address) && $stable(i_io_space_qualifier))[*4];
  endsequence
  // accepted isa read while the inside is busy
  sequence s_busy_read;
    ($fell(i_read_strobe_n) && !o_local_device_decode_n && !i_eisa_mode) ##0 i_reg_busy[*4];
  endsequence
  // accepted strobe edges
  sequence s_wr_end;
    $rose(i_write_strobe_n) && !o_local_device_decode_n;
  endsequence
  sequence s_rd_start;
    $fell(i_read_strobe_n) && !o_local_device_decode_n;
  endsequence
  // ----
  // assertions
  // ----
  a_decode_hit: assert property (s_addr_steady |->
    o_local_device_decode_n == !(i_address[15:4] == i_base_addr && !i_io_space_qualifier))
    else $error("decode output wrong");
  a_write_done: assert property (s_wr_end |-> ##3 o_reg_wr)
    else $error("write pulse missing");
  a_write_cause: assert property ($rose(o_reg_wr) |->
    $past(i_write_strobe_n, 3) && !$past(i_write_strobe_n, 4)) else $error("stray write");
  a_read_lanes: assert property (s_rd_start |->
    ##3 o_reg_rd ##1 (o_data_oe == $past(o_reg_lanes))) else $error("read lanes wrong");
  a_read_release: assert property ($rose(i_read_strobe_n) |-> ##3 o_data_oe == 4'h0)
    else $error("data pins not released");
  a_ready_drop: assert property (s_busy_read |-> !o_async_ready_out)
    else $error("ready not dropped");
  a_ready_back: assert property ($fell(i_reg_busy) && !o_async_ready_out |=>
    o_async_ready_out) else $error("ready not restored");
  a_idle_ready: assert property ((i_read_strobe_n && i_write_strobe_n && !i_reg_busy)[*5]
    |-> o_async_ready_out) else $error("ready low while idle");
  a_eisa_ready: assert property (i_eisa_mode[*4] |-> o_async_ready_out)
    else $error("ready dropped in eisa");
  a_dma_stall: assert property ((!i_exrdy)[*8] |-> !o_dma_wr && !o_dma_rd_taken)
    else $error("dma moved during wait");
  a_isa_no_dma: assert property ((!i_eisa_mode)[*4] |-> !o_dma_wr && !o_dma_rd_taken)
    else $error("dma in isa mode");
endmodule
bind host_port host_port_sva u_sva (.i_clock, .i_sys_rst, .i_eisa_mode, .i_base_addr,
  .i_address, .i_io_space_qualifier, .i_address_strobe_n, .i_read_strobe_n,
  .i_write_strobe_n, .i_reg_busy, .i_exrdy, .o_data_oe, .o_async_ready_out,
  .o_local_device_decode_n, .o_reg_wr, .o_reg_rd, .o_reg_lanes, .o_dma_wr, .o_dma_rd_taken);
`default_nettype wire

// ---- verification/host_bus_model.sv ----
// host bus with its glue logic, facing the host port pins
`default_nettype none
module host_bus_model (
  // clock
  input wire logic i_clock,
  // i/o cycle pins
  output var logic [15:1] o_address,
  output var logic o_qual,
  output var logic o_as_n,
  output var logic [3:0] o_lane_n,
  output var logic o_rd_n,
  output var logic o_wr_n,
  output var logic [31:0] o_dq,
  input wire logic [31:0] i_dq,
  // dma pins
  output var logic o_ack_n,
  output var logic o_dma_write,
  output var logic o_bclk,
  output var logic o_exrdy
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus, isa straps
  initial
  begin
    {o_address, o_as_n, o_dq, o_dma_write, o_bclk} = '0;
    {o_qual, o_lane_n, o_rd_n, o_wr_n, o_ack_n, o_exrdy} = '1;
  end
  // wait falling edges, where all pins change
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // one i/o cycle; rd returns the bus just before the strobe ends
  task automatic io_cycle(input logic eisa, wr, input logic [15:1] a, input logic [3:0] ln,
    input logic [31:0] d, input int hold, output logic [31:0] rd);
    // qualifier is memory select or address enable, both low here
    o_qual = 1'b0 | 1'b0;
    o_address = a;
    // isa ties upper lanes high, lane 0 from a0, lane 1 from byte-high
    o_lane_n = eisa ? ln : {2'b11, ln[1:0]};
    o_as_n = 1'b0;
    // eisa start pulse latches the address on its rise
    if (eisa) idle(3);
    // isa keeps the address strobe tied low, so its latch stays transparent
    o_as_n = eisa;
    idle(4);
    // data driven on the same edge as the strobe, held past its trailing edge
    o_dq = wr ? d : ~o_dq;
    o_wr_n = !wr;
    o_rd_n = wr;
    idle(hold);
    rd = i_dq;
    {o_wr_n, o_rd_n} = 2'b11;
    idle(4);
    o_dq = ~o_dq;
    o_qual = 1'b1;
    idle(2);
  endtask
  // dma burst; the first stall beats ask for wait states
  task automatic dma_burst(input logic wr, input int beats, input int stall);
    o_ack_n = 1'b0;
    o_dma_write = wr;
    idle(4);
    for (int i = 0; i < beats; i++)
    begin
      // one aligned dword per beat, exrdy steady around the bus clock rise
      o_dq = 32'hc0de_0000 + 32'(i);
      o_exrdy = (i >= stall);
      idle(2);
      o_bclk = 1'b1;
      idle(4);
      o_bclk = 1'b0;
      idle(2);
    end
    o_ack_n = 1'b1;
    o_exrdy = 1'b1;
    idle(4);
  endtask
endmodule
`default_nettype wire

// ---- verification/test_host_port.sv ----
// self-checking bench for the isa/eisa host port
`default_nettype none
module test_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // signals
  // ----
  localparam logic [15:4] BASE = 12'h030; // device base address
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_eisa_mode = 1'b0;
  logic i_reg_busy = 1'b0;
  logic [31:0] i_reg_rdata = 32'h0;
  logic [31:0] i_dma_rdata = 32'h7e81_24db;
  logic [15:1] i_address, o_reg_addr, cap_addr;
  logic i_io_space_qualifier, i_address_strobe_n, i_read_strobe_n, i_write_strobe_n;
  logic i_dma_ack_n, i_dma_write, i_bus_clock, i_exrdy, o_async_ready_out;
  logic o_local_device_decode_n, o_reg_wr, o_reg_rd, o_dma_wr, o_dma_rd_taken;
  logic [3:0] i_lane_enable_n, o_data_oe, o_reg_lanes, cap_lanes, cap_oe;
  logic [31:0] dq, o_data, o_wdata, cap_wdata, rd, msk;
  wire [31:0] i_data; // resolved data pins
  int error_cnt = 0;
  int n_tests = 0;
  int n_pulse = 0;
  int dma_cnt = 0;
  // one access: inputs, then the lanes it should use
  typedef struct packed {
    logic eisa;
    logic wr;
    logic [15:1] addr;
    logic [3:0] ln;
    logic [31:0] d;
    logic [3:0] lanes;
  } row_s;
  row_s r;
  row_s rows [10] = '{
    '{1'b0, 1'b1, {BASE, 3'h1}, 4'hc, 32'h0000_a55a, 4'h3},
    '{1'b0, 1'b1, {BASE, 3'h2}, 4'he, 32'h0000_00c3, 4'h1},
    '{1'b0, 1'b1, {BASE, 3'h3}, 4'hd, 32'h0000_7e00, 4'h2},
    '{1'b0, 1'b0, {BASE, 3'h4}, 4'hc, 32'h0000_1ee7, 4'h3},
    '{1'b0, 1'b0, {BASE, 3'h5}, 4'he, 32'h0000_0081, 4'h1},
    '{1'b0, 1'b0, {BASE, 3'h6}, 4'hd, 32'h0000_f000, 4'h2},
    '{1'b1, 1'b1, {BASE, 3'h3}, 4'h0, 32'h89ab_cdef, 4'hf},
    '{1'b1, 1'b0, {BASE, 3'h5}, 4'hc, 32'h4455_6677, 4'h3},
    '{1'b1, 1'b1, {BASE, 3'h7}, 4'h3, 32'h1234_5678, 4'hc},
    '{1'b1, 1'b0, {BASE, 3'h1}, 4'h7, 32'hdead_0042, 4'h8}};
  // ----
  // clock, pins and instances
  // ----
  always #25 i_clock = ~i_clock;
  // each lane shows the port when it drives, else the host side
  for (genvar l = 0; l < 4; l++)
  begin : g_lane
    assign i_data[8*l+:8] = o_data_oe[l] ? o_data[8*l+:8] : dq[8*l+:8];
  end
  host_bus_model bus (.i_clock, .o_address(i_address), .o_qual(i_io_space_qualifier),
    .o_as_n(i_address_strobe_n), .o_lane_n(i_lane_enable_n), .o_rd_n(i_read_strobe_n),
    .o_wr_n(i_write_strobe_n), .o_dq(dq), .i_dq(i_data), .o_ack_n(i_dma_ack_n),
    .o_dma_write(i_dma_write), .o_bclk(i_bus_clock), .o_exrdy(i_exrdy));
  host_port uut (.i_clock, .i_sys_rst, .i_eisa_mode, .i_base_addr(BASE), .i_address,
    .i_io_space_qualifier, .i_address_strobe_n, .i_lane_enable_n, .i_read_strobe_n,
    .i_write_strobe_n, .i_data, .o_data, .o_data_oe, .o_async_ready_out,
    .o_local_device_decode_n, .i_dma_ack_n, .i_dma_write, .i_bus_clock, .i_exrdy,
    .i_reg_busy, .i_reg_rdata, .o_reg_wr, .o_reg_rd, .o_reg_addr, .o_reg_lanes, .o_wdata,
    .i_dma_rdata, .o_dma_wr, .o_dma_rd_taken);
  // ----
  // compare, verdict and watchdog
  // ----
  task automatic chk(input string name, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    end_sim();
  end
  // capture what the inside side is told, check dma beats
  always @(posedge i_clock)
  begin
    if (o_reg_wr || o_reg_rd)
      n_pulse++;
    if (o_reg_wr || o_reg_rd)
      {cap_lanes, cap_addr} = {o_reg_lanes, o_reg_addr};
    if (o_reg_wr)
      cap_wdata = o_wdata;
    if (|o_data_oe)
      cap_oe = o_data_oe;
    if (o_dma_wr)
      chk("dma data", 32'hc0de_0002 + 32'(dma_cnt), o_wdata);
    if (o_dma_rd_taken)
      chk("dma oe", 32'hf, 32'(o_data_oe));
    if (o_dma_rd_taken)
      chk("dma rdata", i_dma_rdata, o_data);
    if (o_dma_wr || o_dma_rd_taken)
      dma_cnt++;
  end
  // ----
  // tests
  // ----
  initial
  begin
    repeat (16) @(negedge i_clock);
    chk("ready", 32'h1, 32'(o_async_ready_out));
    chk("decode", 32'h1, 32'(o_local_device_decode_n));
    chk("oe", 32'h0, 32'(o_data_oe));
    i_sys_rst = 1'b0;
    // table of plain accesses in both modes
    foreach (rows[k])
    begin
      r = rows[k];
      i_eisa_mode = r.eisa;
      i_reg_rdata = r.d;
      {n_pulse, cap_oe} = '0;
      bus.idle(4);
      bus.io_cycle(r.eisa, r.wr, r.addr, r.ln, r.d, 6, rd);
      for (int l = 0; l < 4; l++)
        msk[8*l+:8] = {8{r.lanes[l]}};
      chk("pulses", 32'h1, 32'(n_pulse));
      chk("lanes", 32'(r.lanes), 32'(cap_lanes));
      chk("addr", 32'({r.addr[15:2], r.addr[1] & ~r.eisa}), 32'(cap_addr));
      chk("data", r.d & msk, (r.wr ? cap_wdata : rd) & msk);
      chk("oe", r.wr ? 32'h0 : 32'(r.lanes), 32'(cap_oe));
    end
    // address outside the window is ignored
    n_pulse = 0;
    bus.io_cycle(1'b1, 1'b1, {BASE + 12'h1, 3'h0}, 4'h0, 32'h0, 6, rd);
    chk("miss pulses", 32'h0, 32'(n_pulse));
    // busy read: ready drops in isa only
    for (int m = 0; m < 2; m++)
    begin
      i_eisa_mode = m[0];
      i_reg_busy = 1'b1;
      bus.idle(4);
      fork
        bus.io_cycle(m[0], 1'b0, {BASE, 3'h0}, 4'h0, 32'h0, 10, rd);
        begin
          bus.idle(m ? 13 : 10);
          chk("busy ready", 32'(m), 32'(o_async_ready_out));
          i_reg_busy = 1'b0;
        end
      join
    end
    // dma bursts: refused in isa, paced by exrdy in eisa
    for (int m = 0; m < 2; m++)
    begin
      i_eisa_mode = m[0];
      dma_cnt = 0;
      bus.idle(4);
      bus.dma_burst(1'b1, 4, 2);
      chk("dma writes", 32'(2 * m), 32'(dma_cnt));
      dma_cnt = 0;
      bus.dma_burst(1'b0, 3, 0);
      chk("dma reads", 32'(3 * m), 32'(dma_cnt));
    end
    // mid-run reset: the latched hit from the last eisa read must clear
    i_sys_rst = 1'b1;
    bus.idle(3);
    chk("reset decode", 32'h1, 32'(o_local_device_decode_n));
    chk("reset ready", 32'h1, 32'(o_async_ready_out));
    i_sys_rst = 1'b0;
    bus.idle(4);
    chk("decode after reset", 32'h1, 32'(o_local_device_decode_n));
    end_sim();
  end
endmodule
`default_nettype wire
